// ---- verilog/aod_consts.svh ----
// opcode fields, sub-opcodes and clock counts for the arithmetic decoder
`ifndef AOD_CONSTS_SVH
`define AOD_CONSTS_SVH

// segment override prefix bytes
`define AOD_PFX_CODE 8'h2e
`define AOD_PFX_STACK 8'h36
`define AOD_PFX_DATA 8'h3e
`define AOD_PFX_EXTRA 8'h26

// six-bit opcode heads of the register/memory with register forms, the immediate group and the immediate signed product
`define AOD_SUM_RR 6'h00
`define AOD_CSUM_RR 6'h04
`define AOD_DIFF_RR 6'h0a
`define AOD_BDIFF_RR 6'h06
`define AOD_IMM_GRP 6'h20
`define AOD_SPIMM 6'h1a

// seven-bit opcode heads of the accumulator and unary group forms
`define AOD_SUM_ACC 7'h02
`define AOD_CSUM_ACC 7'h0a
`define AOD_DIFF_ACC 7'h16
`define AOD_BDIFF_ACC 7'h0e
`define AOD_UNARY_GRP 7'h7b

// whole single and two-byte opcodes
`define AOD_UBCD_SUM 8'h37
`define AOD_UBCD_DIFF 8'h3f
`define AOD_PBCD_SUM 8'h27
`define AOD_PBCD_DIFF 8'h2f
`define AOD_BCD_PROD 8'hd4
`define AOD_BCD_DIVD 8'hd5
`define AOD_BCD_CONST 8'h0a
`define AOD_BSEXT 8'h98
`define AOD_WSEXT 8'h99

// sub-opcodes in the reg field of the modrm byte, then mod and rm field values
`define AOD_SUB_SUM 3'h0
`define AOD_SUB_CSUM 3'h2
`define AOD_SUB_BDIFF 3'h3
`define AOD_SUB_DIFF 3'h5
`define AOD_SUB_NEG 3'h3
`define AOD_SUB_UPROD 3'h4
`define AOD_SUB_SPROD 3'h5
`define AOD_SUB_UQUO 3'h6
`define AOD_SUB_SQUO 3'h7
`define AOD_MOD_REG 2'h3
`define AOD_RM_DIRECT 3'h6

// clock counts, single figures
`define AOD_T_PREFIX 7'h02
`define AOD_T_ALU_RR 7'h03
`define AOD_T_ALU_RM 7'h0a
`define AOD_T_ALU_IR 7'h04
`define AOD_T_ALU_IM 7'h10
`define AOD_T_ACC_B 7'h03
`define AOD_T_ACC_W 7'h04
`define AOD_T_NEG_R 7'h03
`define AOD_T_NEG_M 7'h0a
`define AOD_T_WORD_MEM 7'h04
`define AOD_T_UBCD_SUM 7'h08
`define AOD_T_UBCD_DIFF 7'h07
`define AOD_T_PBCD 7'h04
`define AOD_T_BCD_PROD 7'h13
`define AOD_T_BCD_DIVD 7'h0f
`define AOD_T_BSEXT 7'h02
`define AOD_T_WSEXT 7'h04

// clock counts as {least, most}: reg byte, reg word, mem byte, mem word
`define AOD_T_UPROD_RB {7'h1a, 7'h1c}
`define AOD_T_UPROD_RW {7'h23, 7'h25}
`define AOD_T_UPROD_MB {7'h20, 7'h22}
`define AOD_T_UPROD_MW {7'h29, 7'h2b}
`define AOD_T_SPROD_RB {7'h19, 7'h1c}
`define AOD_T_SPROD_RW {7'h22, 7'h25}
`define AOD_T_SPROD_MB {7'h1f, 7'h22}
`define AOD_T_SPROD_MW {7'h28, 7'h2b}
`define AOD_T_SPIMM_R {7'h16, 7'h19}
`define AOD_T_SPIMM_M {7'h1d, 7'h20}
`define AOD_T_UQUO_RB {7'h1d, 7'h1d}
`define AOD_T_UQUO_RW {7'h26, 7'h26}
`define AOD_T_UQUO_MB {7'h23, 7'h23}
`define AOD_T_UQUO_MW {7'h2c, 7'h2c}
`define AOD_T_SQUO_RB {7'h2c, 7'h34}
`define AOD_T_SQUO_RW {7'h35, 7'h3d}
`define AOD_T_SQUO_MB {7'h32, 7'h3a}
`define AOD_T_SQUO_MW {7'h3b, 7'h43}

`endif

// ---- verilog/aod_pkg.sv ----
// types shared by the arithmetic decoder files
package aod_pkg;
  typedef enum logic [4:0] {
    OP_NONE, OP_PREFIX, OP_SUM, OP_CARRY_SUM, OP_DIFF, OP_BORROW_DIFF,
    OP_TWOS_NEGATE, OP_UNPACKED_BCD_SUM_FIX, OP_UNPACKED_BCD_DIFF_FIX,
    OP_PACKED_BCD_SUM_FIX, OP_PACKED_BCD_DIFF_FIX, OP_UNSIGNED_PRODUCT,
    OP_SIGNED_PRODUCT, OP_SIGNED_PRODUCT_IMM, OP_UNSIGNED_QUOTIENT,
    OP_SIGNED_QUOTIENT, OP_BCD_PRODUCT_FIX, OP_BCD_DIVIDEND_FIX,
    OP_BYTE_SIGN_EXTEND, OP_WORD_SIGN_EXTEND
  } aod_op_e;
  typedef enum logic [2:0] {
    FORM_IMPLIED, FORM_RM_REG, FORM_RM_ONLY, FORM_IMM_RM, FORM_IMM_ACC
  } aod_form_e;
  typedef enum logic [2:0] {
    SEG_NONE, SEG_CODE, SEG_STACK, SEG_DATA_SEGMENT_BASE,
    SEG_EXTRA_SEGMENT_BASE
  } aod_seg_e;
  typedef enum logic [2:0] {
    ST_OPCODE, ST_MODRM, ST_DISP, ST_IMM, ST_CONST
  } aod_state_e;
endpackage : aod_pkg

// ---- verilog/aod_exec_timer.sv ----
// execution clock counter that holds the byte stream while it runs
`timescale 1ns/1ps
module aod_exec_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [6:0] count,
  output logic idle_ff,
  output logic done_ff
);
  logic [6:0] cnt_ff;

  // busy for exactly count cycles after the load edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 7'h00;
      idle_ff <= 1'b1;
    end else if (load && count != 7'h00) begin
      cnt_ff <= count;
      idle_ff <= 1'b0;
    end else if (cnt_ff > 7'h01) begin
      cnt_ff <= cnt_ff - 7'h01;
    end else if (cnt_ff == 7'h01) begin
      cnt_ff <= 7'h00;
      idle_ff <= 1'b1;
    end
  end

  // one-cycle pulse as the count runs out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= (cnt_ff == 7'h01) && !load;
    end
  end

  a_timer_step: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_ff > 7'h01 && !load) |=> cnt_ff == $past(cnt_ff) - 7'h01)
    else $error("execution counter skipped a step");
  a_timer_idle: assert property (@(posedge clk) disable iff (!rst_n)
    idle_ff == (cnt_ff == 7'h00))
    else $error("idle flag disagrees with counter");
endmodule : aod_exec_timer

// ---- verilog/aod_decoder.sv ----
// arithmetic group and segment prefix decoder with execution timing
//
// Summary of operation
// - four segment prefixes, two clocks each
// - word memory operand adds four clocks to the sum, difference and negate forms
// - plain sum: three forms, 3/10, 4/16, 3/4
// - carry sum: own opcodes, sub 010
// - plain difference: own opcodes, sub 101
// - borrow difference: own opcodes, sub 011
// - negate via unary group sub 011, 3/10
// - unpacked bcd fixes take 8 and 7
// - packed bcd fixes take 4 each
// - unsigned product sub 100, four timing ranges
// - signed product sub 101, four timing ranges
// - immediate signed product, immediate width by s
// - unsigned quotient sub 110, four fixed times
// - signed quotient sub 111, four timing ranges
// - bcd product fix: two bytes, 19 clocks
// - bcd dividend fix: two bytes, 15 clocks
// - byte sign extend takes 2 clocks
// - word sign extend takes 4 clocks
`timescale 1ns/1ps
`include "aod_consts.svh"
module aod_decoder (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic BYTE_VALID,
  input wire logic [7:0] BYTE_DATA,
  output logic BYTE_READY,
  output logic DONE,
  output logic UNKNOWN,
  output aod_pkg::aod_op_e OP_CLASS,
  output aod_pkg::aod_form_e OP_FORM,
  output aod_pkg::aod_seg_e SEG_PREFIX,
  output logic WORD_SIZE,
  output logic REG_IS_DEST,
  output logic SIGN_EXT_IMM,
  output logic MEM_OPERAND,
  output logic [1:0] DISP_BYTES,
  output logic [1:0] IMM_BYTES,
  output logic [6:0] CLK_MIN,
  output logic [6:0] CLK_MAX,
  output logic EXEC_DONE
);
  import aod_pkg::*;

  aod_state_e state_ff, nxt_state;
  aod_op_e op_ff, nxt_op;
  aod_form_e form_ff, nxt_form;
  aod_seg_e seg_ff;
  logic w_ff, nxt_w, d_ff, nxt_d, s_ff, nxt_s, mem_ff, nxt_mem;
  logic [1:0] disp_ff, nxt_disp, imm_ff, nxt_imm;
  logic [1:0] left_ff, nxt_left;
  logic fin, bad, take, tmr_idle;
  logic [13:0] cyc;
  logic done_ff, unknown_ff, word_ff, dest_ff, sext_ff, memo_ff;
  aod_op_e op_o_ff;
  aod_form_e form_o_ff;
  aod_seg_e seg_o_ff;
  logic [1:0] disp_o_ff, imm_o_ff;
  logic [6:0] min_ff, max_ff;

  // clock counts {least, most} for a decoded instruction
  function automatic logic [13:0] aod_cycles(aod_op_e op, aod_form_e f,
                                             logic w, logic m);
    logic [6:0] t;
    logic [13:0] r;
    t = 7'h00;
    r = 14'h0000;
    case (op)
      OP_SUM, OP_CARRY_SUM, OP_DIFF, OP_BORROW_DIFF: begin
        if (f == FORM_IMM_ACC) begin
          t = w ? `AOD_T_ACC_W : `AOD_T_ACC_B;
        end else if (f == FORM_IMM_RM) begin
          t = m ? `AOD_T_ALU_IM : `AOD_T_ALU_IR;
        end else begin
          t = m ? `AOD_T_ALU_RM : `AOD_T_ALU_RR;
        end
        if (f != FORM_IMM_ACC && m && w) begin
          t = t + `AOD_T_WORD_MEM;
        end
        r = {t, t};
      end
      OP_TWOS_NEGATE: begin
        t = m ? `AOD_T_NEG_M : `AOD_T_NEG_R;
        if (m && w) begin
          t = t + `AOD_T_WORD_MEM;
        end
        r = {t, t};
      end
      OP_PREFIX: r = {`AOD_T_PREFIX, `AOD_T_PREFIX};
      OP_UNPACKED_BCD_SUM_FIX: r = {`AOD_T_UBCD_SUM, `AOD_T_UBCD_SUM};
      OP_UNPACKED_BCD_DIFF_FIX: begin
        r = {`AOD_T_UBCD_DIFF, `AOD_T_UBCD_DIFF};
      end
      OP_PACKED_BCD_SUM_FIX, OP_PACKED_BCD_DIFF_FIX: begin
        r = {`AOD_T_PBCD, `AOD_T_PBCD};
      end
      OP_UNSIGNED_PRODUCT: begin
        case ({m, w})
          2'h0: r = `AOD_T_UPROD_RB;
          2'h1: r = `AOD_T_UPROD_RW;
          2'h2: r = `AOD_T_UPROD_MB;
          default: r = `AOD_T_UPROD_MW;
        endcase
      end
      OP_SIGNED_PRODUCT: begin
        case ({m, w})
          2'h0: r = `AOD_T_SPROD_RB;
          2'h1: r = `AOD_T_SPROD_RW;
          2'h2: r = `AOD_T_SPROD_MB;
          default: r = `AOD_T_SPROD_MW;
        endcase
      end
      OP_SIGNED_PRODUCT_IMM: r = m ? `AOD_T_SPIMM_M : `AOD_T_SPIMM_R;
      OP_UNSIGNED_QUOTIENT: begin
        case ({m, w})
          2'h0: r = `AOD_T_UQUO_RB;
          2'h1: r = `AOD_T_UQUO_RW;
          2'h2: r = `AOD_T_UQUO_MB;
          default: r = `AOD_T_UQUO_MW;
        endcase
      end
      OP_SIGNED_QUOTIENT: begin
        case ({m, w})
          2'h0: r = `AOD_T_SQUO_RB;
          2'h1: r = `AOD_T_SQUO_RW;
          2'h2: r = `AOD_T_SQUO_MB;
          default: r = `AOD_T_SQUO_MW;
        endcase
      end
      OP_BCD_PRODUCT_FIX: r = {`AOD_T_BCD_PROD, `AOD_T_BCD_PROD};
      OP_BCD_DIVIDEND_FIX: r = {`AOD_T_BCD_DIVD, `AOD_T_BCD_DIVD};
      OP_BYTE_SIGN_EXTEND: r = {`AOD_T_BSEXT, `AOD_T_BSEXT};
      OP_WORD_SIGN_EXTEND: r = {`AOD_T_WSEXT, `AOD_T_WSEXT};
      default: r = 14'h0000;
    endcase
    return r;
  endfunction : aod_cycles

  assign take = BYTE_VALID && tmr_idle;

  // next decode state from the byte being taken
  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_form = form_ff;
    nxt_w = w_ff;
    nxt_d = d_ff;
    nxt_s = s_ff;
    nxt_mem = mem_ff;
    nxt_disp = disp_ff;
    nxt_imm = imm_ff;
    nxt_left = left_ff;
    fin = 1'b0;
    bad = 1'b0;
    if (take) begin
      unique case (state_ff)
        ST_OPCODE: begin
          nxt_w = BYTE_DATA[0];
          nxt_d = BYTE_DATA[1];
          nxt_s = BYTE_DATA[1];
          nxt_mem = 1'b0;
          nxt_disp = 2'h0;
          nxt_imm = 2'h0;
          nxt_form = FORM_IMPLIED;
          nxt_op = OP_NONE;
          nxt_state = ST_MODRM;
          if (BYTE_DATA == `AOD_PFX_CODE || BYTE_DATA == `AOD_PFX_STACK ||
              BYTE_DATA == `AOD_PFX_DATA || BYTE_DATA == `AOD_PFX_EXTRA) begin
            nxt_op = OP_PREFIX;
          end else if (BYTE_DATA[7:2] == `AOD_SUM_RR) begin
            nxt_op = OP_SUM;
            nxt_form = FORM_RM_REG;
          end else if (BYTE_DATA[7:2] == `AOD_CSUM_RR) begin
            nxt_op = OP_CARRY_SUM;
            nxt_form = FORM_RM_REG;
          end else if (BYTE_DATA[7:2] == `AOD_DIFF_RR) begin
            nxt_op = OP_DIFF;
            nxt_form = FORM_RM_REG;
          end else if (BYTE_DATA[7:2] == `AOD_BDIFF_RR) begin
            nxt_op = OP_BORROW_DIFF;
            nxt_form = FORM_RM_REG;
          end else if (BYTE_DATA[7:1] == `AOD_SUM_ACC) begin
            nxt_op = OP_SUM;
            nxt_form = FORM_IMM_ACC;
          end else if (BYTE_DATA[7:1] == `AOD_CSUM_ACC) begin
            nxt_op = OP_CARRY_SUM;
            nxt_form = FORM_IMM_ACC;
          end else if (BYTE_DATA[7:1] == `AOD_DIFF_ACC) begin
            nxt_op = OP_DIFF;
            nxt_form = FORM_IMM_ACC;
          end else if (BYTE_DATA[7:1] == `AOD_BDIFF_ACC) begin
            nxt_op = OP_BORROW_DIFF;
            nxt_form = FORM_IMM_ACC;
          end else if (BYTE_DATA[7:2] == `AOD_IMM_GRP) begin
            nxt_form = FORM_IMM_RM;
          end else if (BYTE_DATA[7:1] == `AOD_UNARY_GRP) begin
            nxt_form = FORM_RM_ONLY;
          end else if (BYTE_DATA[7:2] == `AOD_SPIMM && BYTE_DATA[0]) begin
            nxt_op = OP_SIGNED_PRODUCT_IMM;
            nxt_form = FORM_IMM_RM;
          end else if (BYTE_DATA == `AOD_UBCD_SUM) begin
            nxt_op = OP_UNPACKED_BCD_SUM_FIX;
          end else if (BYTE_DATA == `AOD_UBCD_DIFF) begin
            nxt_op = OP_UNPACKED_BCD_DIFF_FIX;
          end else if (BYTE_DATA == `AOD_PBCD_SUM) begin
            nxt_op = OP_PACKED_BCD_SUM_FIX;
          end else if (BYTE_DATA == `AOD_PBCD_DIFF) begin
            nxt_op = OP_PACKED_BCD_DIFF_FIX;
          end else if (BYTE_DATA == `AOD_BCD_PROD) begin
            nxt_op = OP_BCD_PRODUCT_FIX;
            nxt_state = ST_CONST;
          end else if (BYTE_DATA == `AOD_BCD_DIVD) begin
            nxt_op = OP_BCD_DIVIDEND_FIX;
            nxt_state = ST_CONST;
          end else if (BYTE_DATA == `AOD_BSEXT) begin
            nxt_op = OP_BYTE_SIGN_EXTEND;
          end else if (BYTE_DATA == `AOD_WSEXT) begin
            nxt_op = OP_WORD_SIGN_EXTEND;
          end else begin
            bad = 1'b1;
          end
          // accumulator forms carry one data byte, two for a word
          if (nxt_form == FORM_IMM_ACC) begin
            nxt_imm = BYTE_DATA[0] ? 2'h2 : 2'h1;
            nxt_left = nxt_imm;
            nxt_state = ST_IMM;
          end else if (nxt_form == FORM_IMPLIED && nxt_state != ST_CONST) begin
            fin = 1'b1;
            nxt_state = ST_OPCODE;
          end
        end
        ST_MODRM: begin
          nxt_mem = BYTE_DATA[7:6] != `AOD_MOD_REG;
          if (BYTE_DATA[7:6] == 2'h1) begin
            nxt_disp = 2'h1;
          end else if (BYTE_DATA[7:6] == 2'h2 || (BYTE_DATA[7:6] == 2'h0 &&
                       BYTE_DATA[2:0] == `AOD_RM_DIRECT)) begin
            nxt_disp = 2'h2;
          end else begin
            nxt_disp = 2'h0;
          end
          if (op_ff == OP_SIGNED_PRODUCT_IMM) begin
            nxt_imm = s_ff ? 2'h1 : 2'h2;
          end else if (form_ff == FORM_IMM_RM) begin
            nxt_imm = (!s_ff && w_ff) ? 2'h2 : 2'h1;
            unique case (BYTE_DATA[5:3])
              `AOD_SUB_SUM: nxt_op = OP_SUM;
              `AOD_SUB_CSUM: nxt_op = OP_CARRY_SUM;
              `AOD_SUB_DIFF: nxt_op = OP_DIFF;
              `AOD_SUB_BDIFF: nxt_op = OP_BORROW_DIFF;
              default: bad = 1'b1;
            endcase
          end else if (form_ff == FORM_RM_ONLY) begin
            unique case (BYTE_DATA[5:3])
              `AOD_SUB_NEG: nxt_op = OP_TWOS_NEGATE;
              `AOD_SUB_UPROD: nxt_op = OP_UNSIGNED_PRODUCT;
              `AOD_SUB_SPROD: nxt_op = OP_SIGNED_PRODUCT;
              `AOD_SUB_UQUO: nxt_op = OP_UNSIGNED_QUOTIENT;
              `AOD_SUB_SQUO: nxt_op = OP_SIGNED_QUOTIENT;
              default: bad = 1'b1;
            endcase
          end
          if (bad) begin
            fin = 1'b1;
            nxt_state = ST_OPCODE;
          end else if (nxt_disp != 2'h0) begin
            nxt_left = nxt_disp;
            nxt_state = ST_DISP;
          end else if (nxt_imm != 2'h0) begin
            nxt_left = nxt_imm;
            nxt_state = ST_IMM;
          end else begin
            fin = 1'b1;
            nxt_state = ST_OPCODE;
          end
        end
        ST_DISP: begin
          nxt_left = left_ff - 2'h1;
          if (left_ff == 2'h1) begin
            if (imm_ff != 2'h0) begin
              nxt_left = imm_ff;
              nxt_state = ST_IMM;
            end else begin
              fin = 1'b1;
              nxt_state = ST_OPCODE;
            end
          end
        end
        ST_IMM: begin
          nxt_left = left_ff - 2'h1;
          if (left_ff == 2'h1) begin
            fin = 1'b1;
            nxt_state = ST_OPCODE;
          end
        end
        ST_CONST: begin
          bad = BYTE_DATA != `AOD_BCD_CONST;
          fin = 1'b1;
          nxt_state = ST_OPCODE;
        end
      endcase
    end
  end

  assign cyc = bad ? 14'h0000 : aod_cycles(nxt_op, nxt_form, nxt_w, nxt_mem);

  // decode state registers
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state_ff <= ST_OPCODE;
      op_ff <= OP_NONE;
      form_ff <= FORM_IMPLIED;
      w_ff <= 1'b0;
      d_ff <= 1'b0;
      s_ff <= 1'b0;
      mem_ff <= 1'b0;
      disp_ff <= 2'h0;
      imm_ff <= 2'h0;
      left_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      form_ff <= nxt_form;
      w_ff <= nxt_w;
      d_ff <= nxt_d;
      s_ff <= nxt_s;
      mem_ff <= nxt_mem;
      disp_ff <= nxt_disp;
      imm_ff <= nxt_imm;
      left_ff <= nxt_left;
    end
  end

  // pending segment override, consumed by the next instruction
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      seg_ff <= SEG_NONE;
    end else if (fin && nxt_op == OP_PREFIX) begin
      unique case (BYTE_DATA)
        `AOD_PFX_CODE: seg_ff <= SEG_CODE;
        `AOD_PFX_STACK: seg_ff <= SEG_STACK;
        `AOD_PFX_DATA: seg_ff <= SEG_DATA_SEGMENT_BASE;
        default: seg_ff <= SEG_EXTRA_SEGMENT_BASE;
      endcase
    end else if (fin) begin
      seg_ff <= SEG_NONE;
    end
  end

  // decoded result, updated once per finished instruction
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      done_ff <= 1'b0;
      unknown_ff <= 1'b0;
      op_o_ff <= OP_NONE;
      form_o_ff <= FORM_IMPLIED;
      seg_o_ff <= SEG_NONE;
      word_ff <= 1'b0;
      dest_ff <= 1'b0;
      sext_ff <= 1'b0;
      memo_ff <= 1'b0;
      disp_o_ff <= 2'h0;
      imm_o_ff <= 2'h0;
      min_ff <= 7'h00;
      max_ff <= 7'h00;
    end else begin
      done_ff <= fin;
      unknown_ff <= fin && bad;
      if (fin) begin
        op_o_ff <= bad ? OP_NONE : nxt_op;
        form_o_ff <= nxt_form;
        seg_o_ff <= (nxt_op == OP_PREFIX) ? SEG_NONE : seg_ff;
        word_ff <= nxt_w;
        dest_ff <= nxt_d;
        sext_ff <= nxt_s;
        memo_ff <= nxt_mem;
        disp_o_ff <= nxt_disp;
        imm_o_ff <= nxt_imm;
        min_ff <= cyc[13:7];
        max_ff <= cyc[6:0];
      end
    end
  end

  // stall the byte stream for the worst-case execution time
  aod_exec_timer u_timer (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .load(fin),
    .count(cyc[6:0]),
    .idle_ff(tmr_idle),
    .done_ff(EXEC_DONE)
  );

  assign BYTE_READY = tmr_idle;
  assign DONE = done_ff;
  assign UNKNOWN = unknown_ff;
  assign OP_CLASS = op_o_ff;
  assign OP_FORM = form_o_ff;
  assign SEG_PREFIX = seg_o_ff;
  assign WORD_SIZE = word_ff;
  assign REG_IS_DEST = dest_ff;
  assign SIGN_EXT_IMM = sext_ff;
  assign MEM_OPERAND = memo_ff;
  assign DISP_BYTES = disp_o_ff;
  assign IMM_BYTES = imm_o_ff;
  assign CLK_MIN = min_ff;
  assign CLK_MAX = max_ff;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  sequence s_op_taken(logic [7:0] b);
    take && state_ff == ST_OPCODE && BYTE_DATA == b;
  endsequence
  // second byte of the product fix only, so a later dividend fix never counts
  sequence s_const_taken;
    take && state_ff == ST_CONST && op_ff == OP_BCD_PRODUCT_FIX &&
      BYTE_DATA == `AOD_BCD_CONST;
  endsequence

  a_prefix_stall: assert property (s_op_taken(`AOD_PFX_EXTRA) |=>
    DONE && OP_CLASS == OP_PREFIX && !BYTE_READY ##1 !BYTE_READY
    ##1 BYTE_READY) else $error("prefix did not cost two clocks");
  a_word_mem_extra: assert property (DONE && OP_CLASS == OP_SUM &&
    OP_FORM == FORM_RM_REG && MEM_OPERAND && WORD_SIZE |-> CLK_MAX == 7'h0e)
    else $error("word memory sum missing four clocks");
  a_acc_sum_time: assert property (DONE && OP_FORM == FORM_IMM_ACC &&
    OP_CLASS == OP_SUM |-> CLK_MIN == (WORD_SIZE ? 7'h04 : 7'h03))
    else $error("accumulator sum timing wrong");
  a_carry_imm_reg: assert property (DONE && OP_CLASS == OP_CARRY_SUM &&
    OP_FORM == FORM_IMM_RM && !MEM_OPERAND |-> CLK_MIN == 7'h04)
    else $error("carry sum immediate timing wrong");
  a_diff_imm_mem: assert property (DONE && OP_CLASS == OP_DIFF &&
    OP_FORM == FORM_IMM_RM && MEM_OPERAND && !WORD_SIZE |-> CLK_MAX == 7'h10)
    else $error("difference immediate memory timing wrong");
  a_negate_time: assert property (DONE && OP_CLASS == OP_TWOS_NEGATE &&
    !WORD_SIZE |-> CLK_MAX == (MEM_OPERAND ? 7'h0a : 7'h03))
    else $error("negate timing wrong");
  a_unpacked_fix: assert property (s_op_taken(`AOD_UBCD_SUM) |=>
    DONE && OP_CLASS == OP_UNPACKED_BCD_SUM_FIX && CLK_MIN == 7'h08)
    else $error("unpacked bcd sum fix wrong");
  a_packed_fix: assert property (s_op_taken(`AOD_PBCD_DIFF) |=>
    DONE && CLK_MAX == 7'h04 [*1] ##1 !BYTE_READY ##3 BYTE_READY)
    else $error("packed bcd fix wrong");
  a_uproduct_rw: assert property (DONE && OP_CLASS == OP_UNSIGNED_PRODUCT &&
    !MEM_OPERAND && WORD_SIZE |-> CLK_MIN == 7'h23 && CLK_MAX == 7'h25)
    else $error("unsigned product register word timing wrong");
  a_squot_mw: assert property (DONE && OP_CLASS == OP_SIGNED_QUOTIENT &&
    MEM_OPERAND && WORD_SIZE |-> CLK_MIN == 7'h3b && CLK_MAX == 7'h43)
    else $error("signed quotient memory word timing wrong");
  a_bcd_product: assert property (s_op_taken(`AOD_BCD_PROD) ##[1:50]
    s_const_taken |=> DONE && !UNKNOWN && CLK_MAX == 7'h13)
    else $error("bcd product fix wrong");
  a_sign_extend: assert property (s_op_taken(`AOD_WSEXT) |=>
    DONE && OP_CLASS == OP_WORD_SIGN_EXTEND && CLK_MAX == 7'h04)
    else $error("word sign extend wrong");
  a_imm_width: assert property (DONE && OP_FORM == FORM_IMM_RM &&
    OP_CLASS != OP_SIGNED_PRODUCT_IMM && !UNKNOWN |->
    IMM_BYTES == ((!SIGN_EXT_IMM && WORD_SIZE) ? 2'h2 : 2'h1))
    else $error("immediate width wrong");
endmodule : aod_decoder

// ---- tb/aod_decoder_tb.sv ----
// self-checking bench for the arithmetic decoder
`timescale 1ns/1ps
module aod_decoder_tb;
  import aod_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic byte_valid = 1'b0;
  logic [7:0] byte_data = 8'h00;
  logic byte_ready, done, unknown, word_size, reg_is_dest, sign_ext_imm;
  logic mem_operand, exec_done;
  logic [1:0] disp_bytes, imm_bytes;
  logic [6:0] clk_min, clk_max;
  aod_op_e op_class;
  aod_form_e op_form;
  aod_seg_e seg_prefix;
  int n_errors = 0;
  int compares = 0;
  aod_decoder u_aod_decoder (.SYS_CLK(sys_clk), .NRST(nrst),
    .BYTE_VALID(byte_valid), .BYTE_DATA(byte_data),
    .BYTE_READY(byte_ready), .DONE(done), .UNKNOWN(unknown),
    .OP_CLASS(op_class), .OP_FORM(op_form), .SEG_PREFIX(seg_prefix),
    .WORD_SIZE(word_size), .REG_IS_DEST(reg_is_dest),
    .SIGN_EXT_IMM(sign_ext_imm), .MEM_OPERAND(mem_operand),
    .DISP_BYTES(disp_bytes), .IMM_BYTES(imm_bytes), .CLK_MIN(clk_min),
    .CLK_MAX(clk_max), .EXEC_DONE(exec_done));
  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // feed n bytes, then judge decode result and stall length
  task automatic run(int n, logic [47:0] s, logic [7:0] op,
                     logic [7:0] lo, logic [7:0] hi);
    int k;
    int w;
    for (k = n - 1; k >= 0; k--) begin
      @(negedge sys_clk);
      for (w = 0; w < 100 && byte_ready !== 1'b1; w++) @(negedge sys_clk);
      byte_valid = 1'b1;
      byte_data = s[8*k +: 8];
      @(posedge sys_clk);
    end
    @(negedge sys_clk);
    byte_valid = 1'b0;
    chk("done", 8'h01, {7'h00, done});
    chk("unknown", {7'h00, op == 8'h00}, {7'h00, unknown});
    chk("op", op, {3'h0, op_class});
    chk("clk_min", lo, {1'b0, clk_min});
    chk("clk_max", hi, {1'b0, clk_max});
    for (k = 0; k < 100 && byte_ready !== 1'b1; k++) @(negedge sys_clk);
    chk("stall", hi, k[7:0]);
    chk("exec_done", {7'h00, hi != 8'h00}, {7'h00, exec_done});
  endtask : run
  task automatic t_prefix;
    run(1, 48'h2e, OP_PREFIX, 8'h02, 8'h02);
    run(1, 48'h36, OP_PREFIX, 8'h02, 8'h02);
    run(1, 48'h3e, OP_PREFIX, 8'h02, 8'h02);
    run(1, 48'h26, OP_PREFIX, 8'h02, 8'h02);
    run(1, 48'h98, OP_BYTE_SIGN_EXTEND, 8'h02, 8'h02);
    chk("seg", SEG_EXTRA_SEGMENT_BASE, seg_prefix);
    $display("test prefix done");
  endtask : t_prefix
  task automatic t_sum;
    run(2, 48'h03c1, OP_SUM, 8'h03, 8'h03);
    chk("dir", 8'h03, {6'h00, reg_is_dest, word_size});
    run(4, 48'h01063412, OP_SUM, 8'h0e, 8'h0e);
    run(6, 48'h810634127856, OP_SUM, 8'h14, 8'h14);
    chk("imm", 8'h02, {6'h00, imm_bytes});
    chk("form", FORM_IMM_RM, op_form);
    chk("s_m_disp", 8'h06, {4'h0, sign_ext_imm, mem_operand, disp_bytes});
    run(3, 48'h83c005, OP_SUM, 8'h04, 8'h04);
    chk("imm", 8'h01, {6'h00, imm_bytes});
    chk("s_m_disp", 8'h08, {4'h0, sign_ext_imm, mem_operand, disp_bytes});
    run(2, 48'h0405, OP_SUM, 8'h03, 8'h03);
    run(3, 48'h053412, OP_SUM, 8'h04, 8'h04);
    $display("test sum done");
  endtask : t_sum
  task automatic t_subs;
    run(2, 48'h10c0, OP_CARRY_SUM, 8'h03, 8'h03);
    run(3, 48'h80d005, OP_CARRY_SUM, 8'h04, 8'h04);
    run(2, 48'h1405, OP_CARRY_SUM, 8'h03, 8'h03);
    run(2, 48'h28c0, OP_DIFF, 8'h03, 8'h03);
    run(5, 48'h802e341205, OP_DIFF, 8'h10, 8'h10);
    run(4, 48'h29063412, OP_DIFF, 8'h0e, 8'h0e);
    run(3, 48'h2d3412, OP_DIFF, 8'h04, 8'h04);
    run(2, 48'h18c0, OP_BORROW_DIFF, 8'h03, 8'h03);
    run(3, 48'h80d805, OP_BORROW_DIFF, 8'h04, 8'h04);
    run(2, 48'h1c05, OP_BORROW_DIFF, 8'h03, 8'h03);
    $display("test subs done");
  endtask : t_subs
  task automatic t_unary;
    run(2, 48'hf6d8, OP_TWOS_NEGATE, 8'h03, 8'h03);
    run(4, 48'hf71e3412, OP_TWOS_NEGATE, 8'h0e, 8'h0e);
    run(2, 48'hf6e0, OP_UNSIGNED_PRODUCT, 8'h1a, 8'h1c);
    run(2, 48'hf7e0, OP_UNSIGNED_PRODUCT, 8'h23, 8'h25);
    run(2, 48'hf6d0, OP_NONE, 8'h00, 8'h00);
    run(4, 48'hf7263412, OP_UNSIGNED_PRODUCT, 8'h29, 8'h2b);
    run(2, 48'hf7e8, OP_SIGNED_PRODUCT, 8'h22, 8'h25);
    run(4, 48'hf62e3412, OP_SIGNED_PRODUCT, 8'h1f, 8'h22);
    run(2, 48'hf6f0, OP_UNSIGNED_QUOTIENT, 8'h1d, 8'h1d);
    run(4, 48'hf7363412, OP_UNSIGNED_QUOTIENT, 8'h2c, 8'h2c);
    run(2, 48'hf6f8, OP_SIGNED_QUOTIENT, 8'h2c, 8'h34);
    run(4, 48'hf73e3412, OP_SIGNED_QUOTIENT, 8'h3b, 8'h43);
    $display("test unary done");
  endtask : t_unary
  task automatic t_misc;
    run(1, 48'h37, OP_UNPACKED_BCD_SUM_FIX, 8'h08, 8'h08);
    run(1, 48'h3f, OP_UNPACKED_BCD_DIFF_FIX, 8'h07, 8'h07);
    run(1, 48'h27, OP_PACKED_BCD_SUM_FIX, 8'h04, 8'h04);
    run(1, 48'h2f, OP_PACKED_BCD_DIFF_FIX, 8'h04, 8'h04);
    run(1, 48'h99, OP_WORD_SIGN_EXTEND, 8'h04, 8'h04);
    run(2, 48'hd40a, OP_BCD_PRODUCT_FIX, 8'h13, 8'h13);
    run(2, 48'hd50a, OP_BCD_DIVIDEND_FIX, 8'h0f, 8'h0f);
    run(2, 48'hd50b, OP_NONE, 8'h00, 8'h00);
    run(3, 48'h6bc105, OP_SIGNED_PRODUCT_IMM, 8'h16, 8'h19);
    chk("imm", 8'h01, {6'h00, imm_bytes});
    run(4, 48'h69c13412, OP_SIGNED_PRODUCT_IMM, 8'h16, 8'h19);
    chk("imm", 8'h02, {6'h00, imm_bytes});
    run(5, 48'h6b06341205, OP_SIGNED_PRODUCT_IMM, 8'h1d, 8'h20);
    $display("test misc done");
  endtask : t_misc
  task automatic tally_and_finish;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // watchdog against a hung handshake
  initial begin
    #80000;
    n_errors++;
    tally_and_finish();
  end
  // reset, then run every scenario
  initial begin
    repeat (16) @(negedge sys_clk);
    nrst = 1'b1;
    t_prefix();
    t_sum();
    t_subs();
    t_unary();
    t_misc();
    tally_and_finish();
  end
endmodule : aod_decoder_tb
